// *** verilog/rtseq_pkg.sv ***
// package: constants, types and register map of the reset time-out sequencer
package rtseq_pkg;
	// register map (byte addresses on the plain register port)
	localparam logic [7:0] RTSEQ_CORE_STATUS_ADDR = 8'h06;
	localparam logic [7:0] RTSEQ_CTRL_ADDR = 8'h20;
	localparam logic [7:0] RTSEQ_IRQ_STATUS_ADDR = 8'h21;
	localparam logic [7:0] RTSEQ_IRQ_ENABLE_ADDR = 8'h22;
	localparam logic [7:0] RTSEQ_IRQ_CLEAR_ADDR = 8'h23;
	localparam logic [7:0] RTSEQ_CAUSE_ADDR = 8'h24;
	// core status fields
	localparam int RTSEQ_PD_BIT = 2;
	localparam int RTSEQ_TO_BIT = 3;
	localparam int RTSEQ_GLOBAL_IRQ_DISABLE_BIT = 4;
	localparam logic [7:0] RTSEQ_CORE_STATUS_RST = 8'h3c;
	// control register fields
	localparam int RTSEQ_CTRL_OSC_LSB = 0;
	localparam logic [7:0] RTSEQ_CTRL_RST = 8'h00;
	// special function reset values handed to the core
	localparam logic [7:0] RTSEQ_DDR_RST = 8'hff;
	localparam logic [7:0] RTSEQ_PIR_RST = 8'h02;
	localparam logic [15:0] RTSEQ_RESET_VECTOR = 16'h0000;
	// timing
	localparam int RTSEQ_CLK_HZ = 40000000;
	localparam int RTSEQ_POWER_UP_DELAY_TIMER_MS = 96;
	localparam int RTSEQ_POWER_UP_DELAY_TIMER_CYCLES = RTSEQ_CLK_HZ / 1000 * RTSEQ_POWER_UP_DELAY_TIMER_MS;
	localparam int RTSEQ_OST_PERIODS = 1024;
	localparam int RTSEQ_OSC_VALID_SAMPLES = 4;
	// event status bits
	localparam int RTSEQ_EV_POR = 0;
	localparam int RTSEQ_EV_MASTER_CLEAR_N = 1;
	localparam int RTSEQ_EV_WDT = 2;
	localparam int RTSEQ_EV_WAKE = 3;
	localparam int RTSEQ_EV_RELEASE = 4;

	typedef enum logic [1:0]
	{
		RTSEQ_OSC_LF = 2'b00,
		RTSEQ_OSC_XT = 2'b01,
		RTSEQ_OSC_EC = 2'b10,
		RTSEQ_OSC_RC = 2'b11
	} rtseq_osc_e;

	typedef enum logic [2:0]
	{
		RTSEQ_ST_POWER_OFF = 3'b000,
		RTSEQ_ST_WAIT_MASTER_CLEAR_N = 3'b001,
		RTSEQ_ST_TIMEOUT = 3'b010,
		RTSEQ_ST_RUN = 3'b011,
		RTSEQ_ST_SLEEP = 3'b100,
		RTSEQ_ST_WAKE = 3'b101
	} rtseq_state_e;

	// what the core is told at the end of a sequence
	typedef struct packed
	{
		logic load_pc;
		logic [15:0] pc;
		logic force_sfr;
		logic vector_irq;
	} rtseq_restart_s;

	// register port
	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rtseq_reg_req_s;
endpackage : rtseq_pkg

// *** verilog/rtseq_ost.sv ***
// oscillator start-up counter: counts qualified oscillator pulses
`timescale 1ns/10ps
module rtseq_ost
	import rtseq_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic start,
	input wire logic osc_pulse,
	input wire logic osc_valid,
	output logic done
);
	logic [10:0] count;
	logic [2:0] valid_run;
	logic running;
	wire logic osc_ok = (valid_run == 3'(RTSEQ_OSC_VALID_SAMPLES - 1));

	////////////////////////////////////////////////////////////////
	// amplitude qualifier: needs a run of valid samples before counting
	always_ff @(posedge clock)
	begin
		if (!rst_n || start || !osc_valid)
			valid_run <= 3'h0;
		else if (!osc_ok)
			valid_run <= valid_run + 3'h1;
	end

	// count pulses only once amplitude is good
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			count <= 11'h000;
			running <= 1'b0;
			done <= 1'b0;
		end
		else if (start)
		begin
			count <= 11'h000;
			running <= 1'b1;
			done <= 1'b0;
		end
		else if (running && osc_ok && osc_pulse)
		begin
			count <= count + 11'h001;
			if (count == 11'(RTSEQ_OST_PERIODS - 1))
			begin
				running <= 1'b0;
				done <= 1'b1;
			end
		end
	end
endmodule : rtseq_ost

// *** verilog/rtseq_top.sv ***
// reset time-out sequencer: power-up, master clear, watchdog and sleep wake
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
// Contract
// - when power-on detect rises with master clear high, both timers start together.
// - on power-up reset holds for the longer of 96 ms and 1024 oscillator periods.
// - start-up count runs only in crystal or low-frequency modes; wake waits 1024 periods there.
// - the time-out sequence begins at the first rising edge of master clear.
// - no start-up count for master clear or watchdog reset in normal operation.
// - timeout and powerdown flags encode the cause of the last reset or wake.
// - power-on, master clear and watchdog resets restart at address 0000h.
// - interrupt wake continues after sleep, vectoring afterwards if interrupts are enabled.
// - those resets, except watchdog during sleep, force special registers to defined values, unknown ones left alone.
// - interrupt wake leaves special registers alone except wake flags and program counter.
// - reset holds while the power-up delay timer is active.
// - in reset the phase clock sits in first quarter, latch low and strobes high.
// - a watchdog reset during sleep does not force registers to reset state.
// - start-up count counts pulses only once the oscillator reaches valid thresholds.
module rtseq_top
	import rtseq_pkg::*;
#(
	parameter int POWER_UP_DELAY_TIMER_CYCLES = RTSEQ_POWER_UP_DELAY_TIMER_CYCLES
)
(
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic POR_DETECT,
	input wire logic MASTER_CLEAR_N,
	input wire logic OSC_PULSE,
	input wire logic OSC_VALID,
	input wire logic WDT_TIMEOUT,
	input wire logic WATCHDOG_CLEAR_INSTR,
	input wire logic SLEEP_ENTER,
	input wire logic IRQ_WAKE,
	input wire logic EXT_EXEC_MODE,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	output logic CORE_RESET,
	output logic PHASE_HOLD_Q1,
	output logic ALE_OUT,
	output logic OE_N_OUT,
	output logic WR_N_OUT,
	output logic EXT_BUS_OE,
	output rtseq_pkg::rtseq_restart_s RESTART,
	output logic RESTART_VALID,
	output logic [7:0] DDR_RESET_VALUE,
	output logic [7:0] PIR_RESET_VALUE,
	output logic IRQ
);
	import rtseq_pkg::*;

	////////////////////////////////////////////////////////////////
	// pin synchronisers: three stages, change taken when stages 2 and 3 agree
	logic [2:0] por_sync;
	logic [2:0] master_clear_n_sync;
	logic por_lvl;
	logic master_clear_n_lvl;

	always_ff @(posedge CLOCK)
	begin
		por_sync <= RST_N ? {por_sync[1:0], POR_DETECT} : 3'h0;
		master_clear_n_sync <= RST_N ? {master_clear_n_sync[1:0], MASTER_CLEAR_N} : 3'h0;
	end

	// filtered levels only move when the late stages agree
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			por_lvl <= 1'b0;
			master_clear_n_lvl <= 1'b0;
		end
		else
		begin
			if (por_sync[1] == por_sync[2])
				por_lvl <= por_sync[2];
			if (master_clear_n_sync[1] == master_clear_n_sync[2])
				master_clear_n_lvl <= master_clear_n_sync[2];
		end
	end

	////////////////////////////////////////////////////////////////
	// registers and decode
	rtseq_state_e state;
	rtseq_state_e next_state;
	logic [7:0] ctrl;
	logic [7:0] core_status;
	logic [4:0] irq_status;
	logic [4:0] irq_enable;
	logic [2:0] cause;
	logic [23:0] power_up_delay_timer_count;
	logic power_up_delay_timer_active;
	logic ost_start;
	logic ost_done;
	logic ost_needed;
	logic master_clear_n_prev;

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ref_addr);
		addr_hit = (a == ref_addr);
	endfunction : addr_hit

	wire rtseq_osc_e osc_mode = rtseq_osc_e'(ctrl[RTSEQ_CTRL_OSC_LSB +: 2]);
	// crystal-type modes need the start-up count
	wire logic osc_crystal = (osc_mode == RTSEQ_OSC_XT) || (osc_mode == RTSEQ_OSC_LF);
	wire logic master_clear_n_rise = master_clear_n_lvl && !master_clear_n_prev; // prev held low in power-off
	wire logic master_clear_n_low = !master_clear_n_lvl;
	wire logic wr_ctrl = REG_WR && addr_hit(REG_ADDR, RTSEQ_CTRL_ADDR);
	wire logic wr_enable = REG_WR && addr_hit(REG_ADDR, RTSEQ_IRQ_ENABLE_ADDR);
	wire logic wr_clear = REG_WR && addr_hit(REG_ADDR, RTSEQ_IRQ_CLEAR_ADDR);
	wire logic wr_status = REG_WR && addr_hit(REG_ADDR, RTSEQ_CORE_STATUS_ADDR);
	wire logic in_run = (state == RTSEQ_ST_RUN);
	wire logic in_sleep = (state == RTSEQ_ST_SLEEP);
	// timers done
	wire logic timers_done = !power_up_delay_timer_active && (ost_done || !ost_needed);

	wire logic ev_por = (state == RTSEQ_ST_POWER_OFF) && por_lvl;
	wire logic ev_master_clear_n = (in_run || in_sleep || state == RTSEQ_ST_WAKE) && master_clear_n_low;
	wire logic ev_wdt = (in_run || in_sleep) && !master_clear_n_low && WDT_TIMEOUT;
	wire logic ev_wake = in_sleep && !master_clear_n_low && !WDT_TIMEOUT && IRQ_WAKE;
	wire logic ev_release = (state == RTSEQ_ST_TIMEOUT || state == RTSEQ_ST_WAKE)
		&& (next_state == RTSEQ_ST_RUN);
	wire logic [4:0] events = {ev_release, ev_wake, ev_wdt, ev_master_clear_n, ev_por};

	////////////////////////////////////////////////////////////////
	// sequence state machine
	always_comb
	begin
		next_state = state;
		case (state)
			RTSEQ_ST_POWER_OFF:
				if (por_lvl)
					next_state = RTSEQ_ST_WAIT_MASTER_CLEAR_N;
			RTSEQ_ST_WAIT_MASTER_CLEAR_N:
				if (master_clear_n_rise)
					next_state = RTSEQ_ST_TIMEOUT;
			RTSEQ_ST_TIMEOUT:
				if (master_clear_n_low)
					next_state = RTSEQ_ST_WAIT_MASTER_CLEAR_N;
				else if (timers_done)
					next_state = RTSEQ_ST_RUN;
			RTSEQ_ST_RUN:
				if (master_clear_n_low)
					next_state = RTSEQ_ST_WAIT_MASTER_CLEAR_N;
				else if (WDT_TIMEOUT)
					next_state = RTSEQ_ST_TIMEOUT;
				else if (SLEEP_ENTER)
					next_state = RTSEQ_ST_SLEEP;
			RTSEQ_ST_SLEEP:
				if (master_clear_n_low)
					next_state = RTSEQ_ST_WAIT_MASTER_CLEAR_N;
				else if (WDT_TIMEOUT || IRQ_WAKE)
					next_state = RTSEQ_ST_WAKE;
			RTSEQ_ST_WAKE:
				if (master_clear_n_low)
					next_state = RTSEQ_ST_WAIT_MASTER_CLEAR_N;
				else if (ost_done || !ost_needed)
					next_state = RTSEQ_ST_RUN;
			default:
				next_state = RTSEQ_ST_POWER_OFF;
		endcase
		// loss of power detect always wins
		if (!por_lvl)
			next_state = RTSEQ_ST_POWER_OFF;
	end

	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
			state <= RTSEQ_ST_POWER_OFF;
		else
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////
	// power-up delay timer: only the power-up entry runs it, master clear entries do not
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			power_up_delay_timer_count <= 24'h000000;
			power_up_delay_timer_active <= 1'b0;
			master_clear_n_prev <= 1'b0;
		end
		else
		begin
			master_clear_n_prev <= master_clear_n_lvl && (state != RTSEQ_ST_POWER_OFF);
			if (state == RTSEQ_ST_WAIT_MASTER_CLEAR_N && master_clear_n_rise && cause == 3'(RTSEQ_EV_POR))
			begin
				power_up_delay_timer_count <= 24'(POWER_UP_DELAY_TIMER_CYCLES - 1);
				power_up_delay_timer_active <= 1'b1;
			end
			else if (power_up_delay_timer_count != 24'h000000)
				power_up_delay_timer_count <= power_up_delay_timer_count - 24'h000001;
			else
				power_up_delay_timer_active <= 1'b0;
		end
	end

	// start-up count: power-on and out-of-sleep only, never normal run resets
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
			ost_needed <= 1'b0;
		else if (ost_start)
			ost_needed <= osc_crystal;
		else if (in_run && WDT_TIMEOUT)
			ost_needed <= 1'b0;
	end

	// with the power-up timer, on master clear out of sleep, or on a watchdog or interrupt wake leaving sleep
	assign ost_start = (state == RTSEQ_ST_WAIT_MASTER_CLEAR_N && master_clear_n_rise
		&& (cause != 3'(RTSEQ_EV_MASTER_CLEAR_N) || !core_status[RTSEQ_PD_BIT]))
		|| (in_sleep && next_state == RTSEQ_ST_WAKE);

	rtseq_ost u_ost
	(
		.clock(CLOCK),
		.rst_n(RST_N),
		.start(ost_start && osc_crystal),
		.osc_pulse(OSC_PULSE),
		.osc_valid(OSC_VALID),
		.done(ost_done)
	);

	////////////////////////////////////////////////////////////////
	// cause, status flags and restart decision
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			cause <= 3'(RTSEQ_EV_POR);
			core_status <= RTSEQ_CORE_STATUS_RST;
			RESTART <= '0;
			RESTART_VALID <= 1'b0;
		end
		else
		begin
			RESTART_VALID <= ev_release;
			if (ev_por)
			begin
				cause <= 3'(RTSEQ_EV_POR);
				core_status[RTSEQ_TO_BIT] <= 1'b1;
				core_status[RTSEQ_PD_BIT] <= 1'b1;
				core_status[RTSEQ_GLOBAL_IRQ_DISABLE_BIT] <= 1'b1;
			end
			else if (ev_master_clear_n)
			begin
				cause <= 3'(RTSEQ_EV_MASTER_CLEAR_N);
				core_status[RTSEQ_TO_BIT] <= 1'b1;
				core_status[RTSEQ_PD_BIT] <= in_run;
				core_status[RTSEQ_GLOBAL_IRQ_DISABLE_BIT] <= 1'b1;
			end
			else if (ev_wdt)
			begin
				cause <= 3'(RTSEQ_EV_WDT);
				core_status[RTSEQ_TO_BIT] <= 1'b0;
				core_status[RTSEQ_PD_BIT] <= !in_sleep;
				core_status[RTSEQ_GLOBAL_IRQ_DISABLE_BIT] <= 1'b1;
			end
			else if (ev_wake)
			begin
				cause <= 3'(RTSEQ_EV_WAKE);
				core_status[RTSEQ_TO_BIT] <= 1'b1;
				core_status[RTSEQ_PD_BIT] <= 1'b0;
			end
			else if (in_run && WATCHDOG_CLEAR_INSTR)
			begin
				core_status[RTSEQ_TO_BIT] <= 1'b1;
				core_status[RTSEQ_PD_BIT] <= 1'b1;
			end
			else if (wr_status)
				core_status[RTSEQ_GLOBAL_IRQ_DISABLE_BIT] <= REG_WDATA[RTSEQ_GLOBAL_IRQ_DISABLE_BIT];
			if (ev_release)
			begin
				// wake resumes at pc+1; every reset goes to the vector
				RESTART.load_pc <= (cause != 3'(RTSEQ_EV_WAKE));
				RESTART.pc <= RTSEQ_RESET_VECTOR;
				// watchdog out of sleep restarts at the vector but keeps registers: no forcing
				RESTART.force_sfr <= (cause == 3'(RTSEQ_EV_POR)) || (cause == 3'(RTSEQ_EV_MASTER_CLEAR_N))
					|| (cause == 3'(RTSEQ_EV_WDT) && core_status[RTSEQ_PD_BIT]);
				RESTART.vector_irq <= (cause == 3'(RTSEQ_EV_WAKE))
					&& !core_status[RTSEQ_GLOBAL_IRQ_DISABLE_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// reset and pin outputs
	assign CORE_RESET = !in_run;
	assign PHASE_HOLD_Q1 = CORE_RESET;
	assign EXT_BUS_OE = CORE_RESET && EXT_EXEC_MODE;
	assign ALE_OUT = 1'b0;
	assign OE_N_OUT = 1'b1;
	assign WR_N_OUT = 1'b1;
	assign DDR_RESET_VALUE = RTSEQ_DDR_RST;
	assign PIR_RESET_VALUE = RTSEQ_PIR_RST;

	////////////////////////////////////////////////////////////////
	// control, interrupt status and enable registers; set beats clear
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			ctrl <= RTSEQ_CTRL_RST;
			irq_status <= 5'h00;
			irq_enable <= 5'h00;
		end
		else
		begin
			if (wr_ctrl)
				ctrl <= REG_WDATA;
			if (wr_enable)
				irq_enable <= REG_WDATA[4:0];
			irq_status <= (irq_status & ~(wr_clear ? REG_WDATA[4:0] : 5'h00)) | events;
		end
	end

	assign IRQ = |(irq_status & irq_enable);

	// read data one cycle after the strobe, zero for unmapped addresses
	wire logic [7:0] rd_mux =
		addr_hit(REG_ADDR, RTSEQ_CORE_STATUS_ADDR) ? core_status :
		addr_hit(REG_ADDR, RTSEQ_CTRL_ADDR) ? ctrl :
		addr_hit(REG_ADDR, RTSEQ_IRQ_STATUS_ADDR) ? {3'h0, irq_status} :
		addr_hit(REG_ADDR, RTSEQ_IRQ_ENABLE_ADDR) ? {3'h0, irq_enable} :
		addr_hit(REG_ADDR, RTSEQ_CAUSE_ADDR) ? {5'h00, cause} : 8'h00;

	always_ff @(posedge CLOCK)
	begin
		REG_RDATA <= (RST_N && REG_RD) ? rd_mux : 8'h00;
	end
endmodule : rtseq_top

// *** verif/rtseq_top_assertions.sv ***
// port-level assertions for the reset time-out sequencer, bound into its top
`timescale 1ns/10ps
module rtseq_top_assertions
	import rtseq_pkg::*;
#(
	parameter int POWER_UP_DELAY_TIMER_CYCLES = RTSEQ_POWER_UP_DELAY_TIMER_CYCLES
)
(
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic POR_DETECT,
	input wire logic MASTER_CLEAR_N,
	input wire logic EXT_EXEC_MODE,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic CORE_RESET,
	input wire logic PHASE_HOLD_Q1,
	input wire logic ALE_OUT,
	input wire logic OE_N_OUT,
	input wire logic WR_N_OUT,
	input wire logic EXT_BUS_OE,
	input wire rtseq_pkg::rtseq_restart_s RESTART,
	input wire logic RESTART_VALID
);
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);
	int por_cnt;
	// cycles since supply good, saturated just past the timer so it never wraps
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N || !POR_DETECT)
			por_cnt <= 0;
		else if (por_cnt <= POWER_UP_DELAY_TIMER_CYCLES)
			por_cnt <= por_cnt + 1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// external bus parked while in reset: latch low, strobes high
	property bus_parked;
		CORE_RESET && EXT_EXEC_MODE |-> EXT_BUS_OE && !ALE_OUT && OE_N_OUT && WR_N_OUT;
	endproperty
	a_bus_parked: assert property (bus_parked)
		else $error("external bus not parked during reset");
	a_phase_hold: assert property (PHASE_HOLD_Q1 == CORE_RESET)
		else $error("phase hold differs from core reset");
	a_power_up_delay_timer_min: assert property ($fell(CORE_RESET) |-> por_cnt > POWER_UP_DELAY_TIMER_CYCLES)
		else $error("release before the power-up delay elapsed");
	a_master_clear_n_holds: assert property (!MASTER_CLEAR_N [*6] |-> CORE_RESET)
		else $error("core running with master clear low");
	a_por_holds: assert property (!POR_DETECT [*6] |-> CORE_RESET)
		else $error("core running without supply good");
	a_release_pin: assert property ($fell(CORE_RESET) |-> $past(MASTER_CLEAR_N, 3))
		else $error("release while master clear was low");
	a_restart_next: assert property ($fell(CORE_RESET) |-> RESTART_VALID ##1 !RESTART_VALID)
		else $error("restart pulse missing or too long");
	a_reset_vector: assert property (RESTART_VALID && RESTART.load_pc |-> RESTART.pc == 16'h0000)
		else $error("reset restart not at vector zero");
	a_wake_kept: assert property (RESTART_VALID && !RESTART.load_pc |-> !RESTART.force_sfr)
		else $error("wake forced special registers");
	a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
		else $error("read data not zero outside read slot");
	c_release: cover property ($fell(CORE_RESET));
	c_wake: cover property (RESTART_VALID && !RESTART.load_pc);
	c_vector: cover property (RESTART_VALID && RESTART.vector_irq);
endmodule : rtseq_top_assertions
////////////////////////////////////////////////////////////////////////////////
bind rtseq_top rtseq_top_assertions #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_CYCLES)) rtseq_top_assertions_i
(
	.CLOCK(CLOCK), .RST_N(RST_N), .POR_DETECT(POR_DETECT), .MASTER_CLEAR_N(MASTER_CLEAR_N),
	.EXT_EXEC_MODE(EXT_EXEC_MODE), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.CORE_RESET(CORE_RESET), .PHASE_HOLD_Q1(PHASE_HOLD_Q1), .ALE_OUT(ALE_OUT),
	.OE_N_OUT(OE_N_OUT), .WR_N_OUT(WR_N_OUT), .EXT_BUS_OE(EXT_BUS_OE), .RESTART(RESTART),
	.RESTART_VALID(RESTART_VALID)
);

// *** verif/rtseq_board_model.sv ***
// board reset network on the master clear pin: rc delay after power, push button
`timescale 1ns/10ps
module rtseq_board_model
#(
	parameter int RC_DELAY = 30,
	parameter int PUSH_LEN = 12
)
(
	input wire logic clock,
	input wire logic supply_good,
	input wire logic push,
	output logic master_clear_n
);
	int hold = 0;
	// pin is pulled up, so it reads high the moment the hold runs out
	always @(posedge clock)
	begin
		if (!supply_good)
			hold <= RC_DELAY;
		else if (push)
			hold <= PUSH_LEN;
		else if (hold > 0)
			hold <= hold - 1;
	end
	assign master_clear_n = supply_good && hold == 0;
endmodule : rtseq_board_model

// *** verif/rtseq_top_test.sv ***
// self-checking bench for the reset time-out sequencer
`timescale 1ns/10ps
`define RTSEQ_CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
	$display("Error at %0t: got %h expected %h", $time, got, exp); end end
module rtseq_top_test;
	import rtseq_pkg::*;
	localparam int POWER_UP_DELAY_TIMER_SIM = 50;
	logic CLOCK = 1'b0, RST_N = 1'b0, POR_DETECT = 1'b0, IRQ_WAKE = 1'b0, rd_seen = 1'b0;
	logic OSC_PULSE = 1'b0, OSC_VALID = 1'b0, EXT_EXEC_MODE = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
	logic MASTER_CLEAR_N, CORE_RESET, IRQ, RESTART_VALID;
	logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, d;
	logic [7:0] DDR_RESET_VALUE, PIR_RESET_VALUE;
	logic [3:0] evt = 4'h0;
	rtseq_restart_s RESTART, e;
	logic [7:0] rq[$];
	rtseq_restart_s sq[$];
	int seed = 56, num_errors = 0, n_tests = 0, n, p;
	wire [2:0] rs_got = {RESTART.load_pc, RESTART.force_sfr, RESTART.vector_irq};
	////////////////////////////////////////////////////////////////////////////////
	rtseq_top #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_SIM)) rtseq_top_i
	(
		.CLOCK(CLOCK), .RST_N(RST_N), .POR_DETECT(POR_DETECT), .MASTER_CLEAR_N(MASTER_CLEAR_N),
		.OSC_PULSE(OSC_PULSE), .OSC_VALID(OSC_VALID), .WDT_TIMEOUT(evt[0]),
		.WATCHDOG_CLEAR_INSTR(evt[1]), .SLEEP_ENTER(evt[2]), .IRQ_WAKE(IRQ_WAKE),
		.EXT_EXEC_MODE(EXT_EXEC_MODE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CORE_RESET(CORE_RESET),
		.PHASE_HOLD_Q1(), .ALE_OUT(), .OE_N_OUT(), .WR_N_OUT(), .EXT_BUS_OE(),
		.RESTART(RESTART), .RESTART_VALID(RESTART_VALID), .DDR_RESET_VALUE(DDR_RESET_VALUE),
		.PIR_RESET_VALUE(PIR_RESET_VALUE), .IRQ(IRQ)
	);
	rtseq_board_model rtseq_board_model_i
	(.clock(CLOCK), .supply_good(POR_DETECT), .push(evt[3]), .master_clear_n(MASTER_CLEAR_N));
	////////////////////////////////////////////////////////////////////////////////
	always #12.5 CLOCK = ~CLOCK;
	// random oscillator pulses and bus mode; amplitude comes good at a random moment
	always @(posedge CLOCK)
	begin
		OSC_PULSE <= 1'($random(seed));
		EXT_EXEC_MODE <= 1'($random(seed));
		OSC_VALID <= POR_DETECT & (OSC_VALID | ($random(seed) % 64 == 0));
	end
	// result watcher: read data in the slot after the strobe, restart on its pulse
	always @(posedge CLOCK)
	begin
		if (rd_seen)
		begin
			d = rq.pop_front();
			`RTSEQ_CHK(REG_RDATA, d)
		end
		rd_seen <= REG_RD;
		if (RESTART_VALID === 1'b1)
		begin
			e = sq.pop_front();
			`RTSEQ_CHK(rs_got, {e.load_pc, e.force_sfr, e.vector_irq})
			if (e.load_pc)
				`RTSEQ_CHK(RESTART.pc, e.pc)
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// one register cycle; a read notes its expected value first
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] x);
		if (!w)
			rq.push_back(x);
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_WDATA <= x;
		REG_WR <= w;
		REG_RD <= !w;
		@(posedge CLOCK);
		REG_WR <= 1'b0;
		REG_RD <= 1'b0;
	endtask : bus
	// one-cycle event: 1 watchdog, 2 watchdog clear, 4 sleep, 8 board push
	task automatic fire(input logic [3:0] m);
		@(posedge CLOCK);
		evt <= m;
		@(posedge CLOCK);
		evt <= 4'h0;
	endtask : fire
	// wait for reset, then time the release and count qualified pulses meanwhile
	task automatic seq(input int hi);
		n = 0;
		p = 0;
		while (CORE_RESET !== 1'b1 && n < 50)
		begin
			@(posedge CLOCK);
			n++;
		end
		`RTSEQ_CHK(CORE_RESET, 1'b1)
		for (n = 0; CORE_RESET !== 1'b0 && n < 6000; n++)
		begin
			@(posedge CLOCK);
			p += {31'h0, OSC_PULSE & OSC_VALID};
		end
		`RTSEQ_CHK({CORE_RESET, (n <= hi)}, 2'b01)
	endtask : seq
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (4) @(posedge CLOCK);
		RST_N <= 1'b1;
		bus(0, RTSEQ_CORE_STATUS_ADDR, 8'h3c);
		// power-up in the default slow-crystal mode: start-up count dominates
		sq.push_back('{1'b1, 16'h0000, 1'b1, 1'b0});
		POR_DETECT <= 1'b1;
		seq(6000);
		`RTSEQ_CHK(p >= 1024, 1'b1)
		`RTSEQ_CHK({DDR_RESET_VALUE, PIR_RESET_VALUE}, 16'hff02)
		bus(0, RTSEQ_CAUSE_ADDR, 8'h00);
		bus(1, 8'h30, 8'h5a);
		bus(0, 8'h30, 8'h00);
		bus(1, RTSEQ_IRQ_CLEAR_ADDR, 8'hff);
		bus(0, RTSEQ_IRQ_STATUS_ADDR, 8'h00);
		bus(1, RTSEQ_CORE_STATUS_ADDR, 8'h00);
		bus(0, RTSEQ_CORE_STATUS_ADDR, 8'h2c);
		// watchdog in run: no timers, flags 0/1, registers back to reset state
		sq.push_back('{1'b1, 16'h0000, 1'b1, 1'b0});
		fire(4'h1);
		seq(10);
		bus(0, RTSEQ_CORE_STATUS_ADDR, 8'h34);
		bus(0, RTSEQ_CAUSE_ADDR, 8'h02);
		bus(0, RTSEQ_IRQ_STATUS_ADDR, 8'h14);
		bus(1, RTSEQ_IRQ_ENABLE_ADDR, 8'h10);
		@(posedge CLOCK);
		`RTSEQ_CHK(IRQ, 1'b1)
		bus(1, RTSEQ_IRQ_ENABLE_ADDR, 8'h00);
		@(posedge CLOCK);
		`RTSEQ_CHK(IRQ, 1'b0)
		bus(1, RTSEQ_IRQ_ENABLE_ADDR, 8'h10);
		bus(1, RTSEQ_IRQ_CLEAR_ADDR, 8'h10);
		@(posedge CLOCK);
		`RTSEQ_CHK(IRQ, 1'b0)
		fire(4'h2);
		bus(0, RTSEQ_CORE_STATUS_ADDR, 8'h3c);
		// board push in run: no start-up count even in slow-crystal mode
		sq.push_back('{1'b1, 16'h0000, 1'b1, 1'b0});
		fire(4'h8);
		seq(40);
		bus(0, RTSEQ_CAUSE_ADDR, 8'h01);
		// interrupt wake in crystal mode with interrupts enabled
		bus(1, RTSEQ_CTRL_ADDR, 8'h01);
		bus(1, RTSEQ_CORE_STATUS_ADDR, 8'h00);
		sq.push_back('{1'b0, 16'h0000, 1'b0, 1'b1});
		fire(4'h4);
		repeat (8) @(posedge CLOCK);
		IRQ_WAKE <= 1'b1;
		seq(6000);
		`RTSEQ_CHK(p >= 1024, 1'b1)
		IRQ_WAKE <= 1'b0;
		bus(0, RTSEQ_CORE_STATUS_ADDR, 8'h28);
		bus(0, RTSEQ_CAUSE_ADDR, 8'h03);
		// watchdog during sleep in rc mode: vector zero, no wait, registers kept
		bus(1, RTSEQ_CTRL_ADDR, 8'h03);
		bus(1, RTSEQ_CORE_STATUS_ADDR, 8'h10);
		sq.push_back('{1'b1, 16'h0000, 1'b0, 1'b0});
		fire(4'h4);
		repeat (8) @(posedge CLOCK);
		fire(4'h1);
		seq(10);
		bus(0, RTSEQ_CORE_STATUS_ADDR, 8'h30);
		// board push during sleep in crystal mode: start-up count runs, flags 1/0
		bus(1, RTSEQ_CTRL_ADDR, 8'h01);
		sq.push_back('{1'b1, 16'h0000, 1'b1, 1'b0});
		fire(4'h4);
		repeat (8) @(posedge CLOCK);
		fire(4'h8);
		seq(6000);
		`RTSEQ_CHK(p >= 1024, 1'b1)
		bus(0, RTSEQ_CORE_STATUS_ADDR, 8'h38);
		bus(0, RTSEQ_CAUSE_ADDR, 8'h01);
		report_and_stop();
	end
	// hang guard, well beyond the three longest start-up counts
	initial
	begin
		repeat (25000) @(posedge CLOCK);
		num_errors++;
		report_and_stop();
	end
endmodule : rtseq_top_test
